// ---- logic/mcu_irq_pkg.sv ----
package mcu_irq_pkg;

  // ==========================================================
  // register addresses
  localparam logic [7:0] PORTB_DATA_ADDR    = 8'h01;
  localparam logic [7:0] DDR_BASE_ADDR      = 8'h04;
  localparam logic [7:0] SERIAL_CTRL_ADDR   = 8'h0a;
  localparam logic [7:0] SERIAL_STATUS_ADDR = 8'h0b;
  localparam logic [7:0] SERIAL_DATA_ADDR   = 8'h0c;
  localparam logic [7:0] TIMER_CONTROL_ADDR = 8'h12;
  localparam logic [7:0] TIMER_STATUS_ADDR  = 8'h13;
  localparam logic [7:0] CAPTURE_LO_ADDR    = 8'h15;
  localparam logic [7:0] COMPARE_LO_ADDR    = 8'h17;
  localparam logic [7:0] COUNT_LO_ADDR      = 8'h19;
  localparam logic [7:0] SPECIAL_PORT_ADDR  = 8'h1e;
  localparam int         NUM_DDR            = 4;

  // ==========================================================
  // event flags: capture, compare, overflow, transfer done,
  // mode fault, write collision, keypad port
  localparam int NUM_FLAGS = 7;
  localparam logic [7:0] FLAG_STATUS_ADDR [NUM_FLAGS] = '{
    8'h13, 8'h13, 8'h13, 8'h0b, 8'h0b, 8'h0b, 8'h1e};
  localparam logic [7:0] FLAG_DATA_ADDR [NUM_FLAGS] = '{
    8'h15, 8'h17, 8'h19, 8'h0c, 8'h0c, 8'h0c, 8'h01};

  // ==========================================================
  // field positions
  localparam int TCR_CAPTURE_EN  = 7;
  localparam int TCR_COMPARE_EN  = 6;
  localparam int TCR_OVERFLOW_EN = 5;
  localparam int TCR_EXT_OSC_EN  = 4;
  localparam int TCR_EXT_CLK     = 3;
  localparam int TCR_OUT_LEVEL   = 0;
  localparam int SCR_IRQ_EN      = 7;
  localparam int SCR_ENABLE      = 6;
  localparam int SCR_MASTER      = 4;
  localparam int SPR_FLAG        = 7;
  localparam int SPR_OPEN_DRAIN  = 5;
  localparam int SPR_PORTA_OD    = 4;
  localparam int SPR_DELAY_OVR   = 2;
  localparam int SPR_KEYPAD_EN   = 1;

  // ==========================================================
  // vectors, stack, reset values, delays
  localparam logic [12:0] VEC_RESET  = 13'h1ffe;
  localparam logic [12:0] VEC_SWI    = 13'h1ffc;
  localparam logic [12:0] VEC_EXT    = 13'h1ffa;
  localparam logic [12:0] VEC_TIMER  = 13'h1ff8;
  localparam logic [12:0] VEC_SERIAL = 13'h1ff4;
  localparam logic [12:0] VEC_KEYPAD = 13'h1ff2;
  localparam logic [6:0]  STACK_PAGE = 7'h03;
  localparam logic [5:0]  SP_TOP     = 6'h3f;
  localparam logic [5:0]  SP_FRAME   = 6'h05;
  localparam logic [15:0] TIMER_RESET_COUNT = 16'hfffc;
  localparam logic [11:0] DELAY_LONG_CYC    = 12'hfe0;
  localparam logic [11:0] DELAY_SHORT_CYC   = 12'h002;

  typedef enum logic [2:0] {
    ST_POWERUP = 3'b000,
    ST_HOLD    = 3'b001,
    ST_VECTOR  = 3'b010,
    ST_RUN     = 3'b011,
    ST_WAIT    = 3'b100,
    ST_STOP    = 3'b101,
    ST_WAKE    = 3'b110
  } seq_state_e;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } bus_req_s;

  typedef struct packed {
    logic boundary;
    logic software_trap;
    logic return_from_trap;
    logic rti_mask;
    logic set_mask;
    logic clr_mask;
    logic stop;
    logic wait_i;
  } cpu_req_s;

  typedef struct packed {
    logic keypad_low;
    logic write_collision;
    logic mode_fault;
    logic transfer_done;
    logic overflow;
    logic compare;
    logic capture;
  } periph_evt_s;

  typedef struct packed {
    logic        run;
    logic        osc_on;
    logic        vec_stb;
    logic        push_stb;
    logic [12:0] vector;
    logic        mask;
    logic [12:0] sp_addr;
  } cpu_ctl_s;

  typedef struct packed {
    logic                    timer_init;
    logic                    ext_osc_en;
    logic                    ext_clk_sel;
    logic                    cmp_out;
    logic                    serial_enable;
    logic                    serial_master;
    logic                    open_drain;
    logic                    porta_open_drain;
    logic [NUM_DDR-1:0][7:0] ddr;
  } periph_ctl_s;

  typedef struct packed {
    seq_state_e              st;
    logic [11:0]             cnt;
    logic                    mask;
    logic [5:0]              sp;
    logic [7:0]              timer_control;
    logic [7:0]              scr;
    logic [7:0]              spr;
    logic [NUM_DDR-1:0][7:0] ddr;
    logic [NUM_FLAGS-1:0]    flag;
    logic [NUM_FLAGS-1:0]    armed;
    logic                    ext_latch;
    logic                    irq_prev;
    logic                    cmp_out;
    logic [7:0]              rdata;
    logic                    vec_stb;
    logic                    push_stb;
    logic [12:0]             vector;
    logic                    run;
    logic                    osc_on;
    logic                    timer_init;
  } ctl_state_s;

endpackage

// ---- logic/irq_reset_ctl.sv ----
`timescale 1ns/1ps
// Functional notes
// R1: five sources: external pin, serial, keypad port, timer, plus software trap.
// R2: clear enable blocks the request but the flag still sets.
// R3: reset clears every enable bit.
// R4: flag clears after status read while set, then data register access.
// R5: interrupts are taken only at an instruction boundary.
// R6: entry pushes registers, sets the mask bit, fetches the source vector.
// R7: return restores registers; mask ends clear only if stacked mask was zero.
// R8: priority reset, instruction or trap, external, timer, serial, keypad.
// R9: reset pin low sets the mask and vectors through the reset pair.
// R10: three timer flags in status top bits, one vector, enables in control.
// R11: software trap ignores the mask and uses its own vector.
// R12: external interrupt taken when mask clear and pin driven low.
// R13: build option: level plus falling edge, or falling edge only.
// R14: external latch clears at entry; one further edge may be latched.
// R15: level mode: pin still low after service requests again.
// R16: external pulses spaced by service length plus 21 cycles.
// R17: reset zeroes prescaler, presets counter, clears compare and level bits.
// R18: reset sets ports to input, stack to top, mask set, latches cleared.
// R19: reset disables serial, slave mode, timer oscillator, keypad controls.
// R20: pin low after start-up delay holds reset; sequence starts after rise.
// R21: stop halts oscillator until external, keypad, external-clock timer, reset.
// R22: wait halts the core; any interrupt or reset ends it via normal vectors.
// R23: external request during mask is held and serviced after mask clears.
// R24: each entry uses five stack bytes; six-bit pointer wraps modulo 64.
// R25: start-up and stop-exit delay 4064 or 2 cycles; override forces 2.
module irq_reset_ctl
  import mcu_irq_pkg::*;
#(
  parameter bit LONG_DELAY = 1'b1,  // crystal start-up option
  parameter bit LEVEL_TRIG = 1'b1   // level plus edge external trigger
)(
  input  wire logic        clock,       // 100 MHz processor clock
  input  wire logic        rst,         // power-on reset, async
  input  wire logic        reset_pin_n, // external reset pin
  input  wire logic        irq_pin_n,   // external interrupt pin
  input  wire bus_req_s    bus,         // register port request
  input  wire periph_evt_s evt,         // peripheral flag events
  input  wire cpu_req_s    cpu,         // core boundary reports
  output logic [7:0]       rdata,       // read data, next cycle
  output cpu_ctl_s         cpu_o,       // core control
  output periph_ctl_s      periph_o     // peripheral control
);

  // ==========================================================
  // state register
  // one struct: one comb copy, one flop stage
  ctl_state_s q;
  ctl_state_s d;

  // irq_prev idles high, so no false edge after reset
  localparam ctl_state_s POR_STATE = '{
    st:         ST_POWERUP,
    cnt:        12'h000,
    mask:       1'b1,
    sp:         SP_TOP,
    timer_control:        8'h00,
    scr:        8'h00,
    spr:        8'h00,
    ddr:        '0,
    flag:       '0,
    armed:      '0,
    ext_latch:  1'b0,
    irq_prev:   1'b1,
    cmp_out:    1'b0,
    rdata:      8'h00,
    vec_stb:    1'b0,
    push_stb:   1'b0,
    vector:     VEC_RESET,
    run:        1'b0,
    osc_on:     1'b1,
    timer_init: 1'b1};

  // init applied by the reset pin; flags of the timer survive
  // rdata is kept, so a read in flight still answers
  function automatic ctl_state_s reset_init(input ctl_state_s s);
    ctl_state_s r;
    r = s;
    r.timer_control        = 8'h00;          // see R3, R17, R19
    r.scr        = 8'h00;          // see R19
    r.spr        = 8'h00;          // see R19
    r.flag[5:3]  = 3'b000;         // see R19
    r.armed      = '0;
    r.ddr        = '0;             // see R18
    r.sp         = SP_TOP;         // see R18
    r.mask       = 1'b1;           // see R9, R18
    r.ext_latch  = 1'b0;           // see R18
    r.cmp_out    = 1'b0;           // see R17
    r.timer_init = 1'b1;           // see R17
    r.run        = 1'b0;
    r.osc_on     = 1'b1;
    r.vector     = VEC_RESET;      // see R9
    return r;
  endfunction

  // ==========================================================
  // request decode
  logic [NUM_FLAGS-1:0] evt_vec;
  logic [2:0]           timer_en;
  logic                 ext_req;
  logic                 timer_req;
  logic                 serial_req;
  logic                 keypad_req;
  logic                 hw_req;
  logic [12:0]          hw_vec;
  logic                 wake_req;
  logic [11:0]          delay_last;

  assign evt_vec  = evt;
  assign timer_en = {q.timer_control[TCR_OVERFLOW_EN], q.timer_control[TCR_COMPARE_EN],
                     q.timer_control[TCR_CAPTURE_EN]};

  // enable gates the request only, never the flag
  // level mode keeps asking while the pin stays low
  always_comb
  begin
    ext_req    = q.ext_latch | (LEVEL_TRIG & ~irq_pin_n); // see R13, R15
    timer_req  = |(q.flag[2:0] & timer_en);               // see R2, R10
    serial_req = q.scr[SCR_IRQ_EN] & (q.flag[3] | q.flag[4]); // see R2
    keypad_req = q.spr[SPR_KEYPAD_EN] & q.flag[6];        // see R2
    hw_req     = ext_req | timer_req | serial_req | keypad_req; // see R1
    // fixed order below the trap
    if (ext_req)
      hw_vec = VEC_EXT;                                   // see R8, R12
    else if (timer_req)
      hw_vec = VEC_TIMER;                                 // see R8, R10
    else if (serial_req)
      hw_vec = VEC_SERIAL;                                // see R8
    else
      hw_vec = VEC_KEYPAD;                                // see R8
    // timer wakes stop only when clocked from its own oscillator
    wake_req = ext_req | keypad_req
             | (timer_req & q.timer_control[TCR_EXT_CLK]);          // see R21
    if (LONG_DELAY && !q.spr[SPR_DELAY_OVR])
      delay_last = DELAY_LONG_CYC - 12'h001;              // see R25
    else
      delay_last = DELAY_SHORT_CYC - 12'h001;             // see R25
  end

  // ==========================================================
  // next state
  always_comb
  begin
    logic take;
    logic [12:0] tvec;
    take       = 1'b0;
    tvec       = hw_vec;
    d          = q;
    d.vec_stb  = 1'b0;
    d.push_stb = 1'b0;
    d.rdata    = 8'h00;
    d.irq_prev = irq_pin_n;

    // flag arm and clear sequence; a new event wins over the clear
    // a data access alone never clears
    for (int i = 0; i < NUM_FLAGS; i++)
    begin
      if (bus.rd && bus.addr == FLAG_STATUS_ADDR[i] && q.flag[i])
        d.armed[i] = 1'b1;                                // see R4
      if (q.armed[i] && (bus.rd || bus.wr)
          && bus.addr == FLAG_DATA_ADDR[i])
      begin
        d.flag[i]  = 1'b0;                                // see R4
        d.armed[i] = 1'b0;
      end
      if (evt_vec[i])
        d.flag[i] = 1'b1;                                 // see R2
    end

    // compare match drives the level bit onto the pin
    if (evt.compare)
      d.cmp_out = q.timer_control[TCR_OUT_LEVEL];

    // register writes
    // special port flag bit is read only
    if (bus.wr)
    begin
      case (bus.addr)
        TIMER_CONTROL_ADDR: d.timer_control = bus.wdata;            // see R10
        SERIAL_CTRL_ADDR:   d.scr = bus.wdata;
        SPECIAL_PORT_ADDR:  d.spr = {1'b0, bus.wdata[6:0]};
        default:
        begin
          if (bus.addr[7:2] == DDR_BASE_ADDR[7:2])
            d.ddr[bus.addr[1:0]] = bus.wdata;
        end
      endcase
    end

    // register reads, answered in the next cycle
    // unmapped or idle reads give zero
    if (bus.rd)
    begin
      case (bus.addr)
        TIMER_CONTROL_ADDR: d.rdata = q.timer_control;
        TIMER_STATUS_ADDR:
          d.rdata = {q.flag[0], q.flag[1], q.flag[2], 5'h00}; // see R10
        SERIAL_CTRL_ADDR:   d.rdata = q.scr;
        SERIAL_STATUS_ADDR:
          d.rdata = {q.flag[3], q.flag[5], 1'b0, q.flag[4], 4'h0};
        SPECIAL_PORT_ADDR:  d.rdata = {q.flag[6], q.spr[6:0]};
        default:
        begin
          if (bus.addr[7:2] == DDR_BASE_ADDR[7:2])
            d.rdata = q.ddr[bus.addr[1:0]];
        end
      endcase
    end

    // sequencer
    // stop and wait clear the mask so a wake is taken
    case (q.st)
      ST_POWERUP:
      begin
        // delay runs even while the pin is held low
        d.cnt = q.cnt + 12'h001;
        if (q.cnt >= delay_last)
        begin
          d.cnt = 12'h000;
          d.st  = reset_pin_n ? ST_VECTOR : ST_HOLD;      // see R20
        end
      end
      ST_HOLD:
      begin
        // pin low: the init below repeats each cycle
        if (reset_pin_n)
          d.st = ST_VECTOR;                               // see R20
      end
      ST_VECTOR:
      begin
        // timer leaves its init hold as the core starts
        d.vec_stb    = 1'b1;                              // see R9
        d.vector     = VEC_RESET;
        d.mask       = 1'b1;
        d.timer_init = 1'b0;
        d.run        = 1'b1;
        d.st         = ST_RUN;
      end
      ST_RUN:
      begin
        if (cpu.boundary)                                 // see R5
        begin
          if (cpu.software_trap)
          begin
            take = 1'b1;                                  // see R11
            tvec = VEC_SWI;                               // see R8
          end
          else
          begin
            if (cpu.return_from_trap)
            begin
              d.mask = cpu.rti_mask;                      // see R7
              d.sp   = q.sp + SP_FRAME;                   // see R7, R24
            end
            else if (cpu.set_mask)
              d.mask = 1'b1;
            else if (cpu.clr_mask)
              d.mask = 1'b0;
            if (cpu.stop)
            begin
              d.mask   = 1'b0;                            // see R21
              d.run    = 1'b0;
              d.osc_on = 1'b0;                            // see R21
              d.st     = ST_STOP;
            end
            else if (cpu.wait_i)
            begin
              d.mask = 1'b0;                              // see R22
              d.run  = 1'b0;                              // see R22
              d.st   = ST_WAIT;
            end
            else if (!d.mask && hw_req)
              take = 1'b1;                                // see R12, R23
          end
        end
      end
      ST_WAIT:
      begin
        // no dedicated vector: the normal one is fetched
        if (hw_req)
        begin
          take  = 1'b1;                                   // see R22
          d.run = 1'b1;
          d.st  = ST_RUN;
        end
      end
      ST_STOP:
      begin
        if (wake_req)
        begin
          d.osc_on = 1'b1;                                // see R21
          d.cnt    = 12'h000;
          d.st     = ST_WAKE;
        end
      end
      ST_WAKE:
      begin
        // entry taken on the edge that restarts the core
        d.cnt = q.cnt + 12'h001;
        if (q.cnt >= delay_last)                          // see R25
        begin
          d.cnt = 12'h000;
          d.run = 1'b1;
          d.st  = ST_RUN;
          take  = hw_req;
        end
      end
      default:
        d.st = ST_HOLD;
    endcase

    // entry: push five bytes, mask on, fetch vector
    if (take)
    begin
      d.push_stb = 1'b1;                                  // see R6
      d.vec_stb  = 1'b1;                                  // see R6
      d.vector   = tvec;                                  // see R6
      d.mask     = 1'b1;                                  // see R6
      // a return on this boundary pops first, so the
      // entry right after it reuses the freed bytes
      d.sp       = d.sp - SP_FRAME;                       // see R24
      if (tvec == VEC_EXT)
        d.ext_latch = 1'b0;                               // see R14
    end

    // a falling edge during entry still latches
    if (q.irq_prev && !irq_pin_n)
      d.ext_latch = 1'b1;                                 // see R14, R23

    // pin reset wins over everything but the start-up delay
    // writes while the pin is low are lost
    if (!reset_pin_n && q.st != ST_POWERUP)
    begin
      d      = reset_init(d);                             // see R9, R18
      d.st   = ST_HOLD;                                   // see R20
      d.cnt  = 12'h000;
      d.vec_stb  = 1'b0;
      d.push_stb = 1'b0;
    end
  end

  // async reset loads constants only
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      q <= POR_STATE;
    else
      q <= d;
  end

  // ==========================================================
  // outputs, all straight from the state register
  assign rdata = q.rdata;
  // vector holds until the next fetch
  assign cpu_o = '{run:      q.run,
                   osc_on:   q.osc_on,
                   vec_stb:  q.vec_stb,
                   push_stb: q.push_stb,
                   vector:   q.vector,
                   mask:     q.mask,
                   sp_addr:  {STACK_PAGE, q.sp}};
  assign periph_o = '{timer_init: q.timer_init,
                      ext_osc_en: q.timer_control[TCR_EXT_OSC_EN],
                      ext_clk_sel: q.timer_control[TCR_EXT_CLK],
                      cmp_out: q.cmp_out,
                      serial_enable: q.scr[SCR_ENABLE],
                      serial_master: q.scr[SCR_MASTER],
                      open_drain: q.spr[SPR_OPEN_DRAIN],
                      porta_open_drain: q.spr[SPR_PORTA_OD],
                      ddr: q.ddr};

endmodule

// ---- verif/irq_reset_ctl_asserts.sv ----
`timescale 1ns/1ps
// ==========================================================
// port checks for the interrupt and reset sequencer
module irq_reset_ctl_asserts
  import mcu_irq_pkg::*;
(
  input wire logic        clock,       // processor clock
  input wire logic        rst,         // async reset
  input wire logic        reset_pin_n, // reset pin
  input wire logic        irq_pin_n,   // interrupt pin
  input wire bus_req_s    bus,         // register port
  input wire periph_evt_s evt,         // flag events
  input wire cpu_req_s    cpu,         // core reports
  input wire logic [7:0]  rdata,       // read data
  input wire cpu_ctl_s    cpu_o,       // core control
  input wire periph_ctl_s periph_o     // peripheral control
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);

  // boundary while running, qualifiers without the boundary bit
  logic       bnd;
  logic [6:0] q;
  assign bnd = cpu.boundary && cpu_o.run && reset_pin_n;
  assign q   = cpu[6:0];

  sequence s_entry(logic [12:0] v);
    cpu_o.vec_stb && cpu_o.push_stb && cpu_o.vector == v;
  endsequence
  sequence s_init;
    cpu_o.sp_addr == 13'h00ff && cpu_o.mask && !cpu_o.run &&
    cpu_o.vector == VEC_RESET && periph_o.timer_init &&
    periph_o.ddr == '0 && !periph_o.serial_enable &&
    !periph_o.serial_master && !periph_o.ext_osc_en &&
    !periph_o.ext_clk_sel && !periph_o.cmp_out &&
    !periph_o.open_drain && !periph_o.porta_open_drain;
  endsequence

  property p_init;
    $fell(rst) |-> s_init;
  endproperty
  property p_trap;
    bnd && cpu.software_trap |=> s_entry(VEC_SWI);
  endproperty
  property p_ext;
    bnd && q == 7'h04 && !irq_pin_n && $past(!irq_pin_n)
      |=> s_entry(VEC_EXT);
  endproperty
  property p_masked;
    bnd && cpu_o.mask && q == 7'h00 |=> !cpu_o.vec_stb;
  endproperty
  property p_boundary;
    cpu_o.vec_stb && cpu_o.run && $past(cpu_o.run)
      |-> $past(cpu.boundary);
  endproperty
  property p_mask;
    cpu_o.vec_stb |-> cpu_o.mask;
  endproperty
  property p_stack;
    cpu_o.push_stb |-> cpu_o.sp_addr[12:6] == STACK_PAGE &&
      cpu_o.sp_addr[5:0] + SP_FRAME == $past(cpu_o.sp_addr[5:0])
        + ($past(bnd && q[6:5] == 2'b01) ? SP_FRAME : 6'h00);
  endproperty
  property p_pulse;
    cpu_o.vec_stb |=> !cpu_o.vec_stb && !cpu_o.push_stb;
  endproperty
  property p_ret;
    bnd && q[6:5] == 2'b01 && q[3:0] == 4'h0
      |=> cpu_o.vec_stb || cpu_o.mask == $past(cpu.rti_mask);
  endproperty
  property p_stop;
    bnd && q == 7'h02 && irq_pin_n
      |=> !cpu_o.run && !cpu_o.osc_on ##1 !cpu_o.run;
  endproperty
  property p_pin;
    !reset_pin_n |=> !cpu_o.run && cpu_o.mask && cpu_o.sp_addr == 13'h00ff;
  endproperty

  a_init: assert property (p_init)
    else $error("state after reset wrong");
  a_trap: assert property (p_trap)
    else $error("trap entry missing");
  a_ext: assert property (p_ext)
    else $error("external entry missing");
  a_masked: assert property (p_masked)
    else $error("entry while masked");
  a_boundary: assert property (p_boundary)
    else $error("entry off a boundary");
  a_mask: assert property (p_mask)
    else $error("mask clear at fetch");
  a_stack: assert property (p_stack)
    else $error("stack step wrong");
  a_pulse: assert property (p_pulse)
    else $error("strobe too long");
  a_ret: assert property (p_ret)
    else $error("mask after return wrong");
  a_stop: assert property (p_stop)
    else $error("stop did not halt");
  a_pin: assert property (p_pin)
    else $error("pin reset not applied");
endmodule

// ---- verif/cpu_model.sv ----
`timescale 1ns/1ps
// ==========================================================
// core and interrupt source as seen by the sequencer
module cpu_model
  import mcu_irq_pkg::*;
(
  input  wire logic clock,     // processor clock
  output cpu_req_s  cpu,       // boundary reports
  output logic      irq_pin_n  // external interrupt line
);
  // idle: no boundary, line held high by its pull-up
  initial
  begin
    cpu = '0;
    irq_pin_n = 1'b1;
  end

  // one instruction end, qualified by q, one cycle long
  task automatic step(input logic [6:0] q);
    @(posedge clock);
    cpu <= {1'b1, q};
    @(posedge clock);
    cpu <= '0;
  endtask

  // drives the line level from the next edge; callers may release it mid-service
  task automatic irq(input logic lvl);
    @(posedge clock);
    irq_pin_n <= lvl;
  endtask
endmodule

// ---- verif/tb_irq_reset_ctl.sv ----
`timescale 1ns/1ps
// ==========================================================
// sequencer bench
module tb_irq_reset_ctl
  import mcu_irq_pkg::*;
;
  localparam logic [6:0] Q_NOP = 7'h00, Q_TRAP = 7'h40, Q_RET = 7'h20;
  localparam logic [6:0] Q_MSET = 7'h08, Q_MCLR = 7'h04, Q_RETM = 7'h30;
  localparam logic [6:0] Q_STOP = 7'h02, Q_WAIT = 7'h01;
  logic        clock, rst, reset_pin_n, irq_pin_n;
  bus_req_s    bus;
  periph_evt_s evt;
  cpu_req_s    cpu;
  logic [7:0]  rdata;
  cpu_ctl_s    cpu_o;
  periph_ctl_s periph_o;
  int          mismatches, n_compared, k;
  logic [5:0]  sp_exp;

  irq_reset_ctl #(.LONG_DELAY(1'b0), .LEVEL_TRIG(1'b1)) dut (
    .clock(clock), .rst(rst), .reset_pin_n(reset_pin_n),
    .irq_pin_n(irq_pin_n), .bus(bus), .evt(evt), .cpu(cpu),
    .rdata(rdata), .cpu_o(cpu_o), .periph_o(periph_o));
  cpu_model core_m (.clock(clock), .cpu(cpu), .irq_pin_n(irq_pin_n));

  // 100 MHz clock
  always #5 clock = ~clock;

  task automatic chk(input string nm, input logic [15:0] e,
                     input logic [15:0] g);
    n_compared++;
    if (g !== e)
    begin
      mismatches++;
      $display("Error %s expected %h got %h", nm, e, g);
    end
  endtask

  task automatic results();
    if (mismatches == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clock);
    bus <= '0;
  endtask

  // read data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clock);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clock);
    bus <= '0;
    #1;
    chk("rdata", {8'h00, e}, {8'h00, rdata});
  endtask

  task automatic pulse(input periph_evt_s e);
    @(posedge clock);
    evt <= e;
    @(posedge clock);
    evt <= '0;
  endtask

  task automatic wait_vec(input int n);
    int i;
    for (i = 0; i < n && cpu_o.vec_stb !== 1'b1; i++)
    begin
      @(posedge clock);
      #1;
    end
    chk("vec_stb", 1, cpu_o.vec_stb);
  endtask

  // every entry takes five stack bytes, pointer wraps in 64
  task automatic ent(input logic [12:0] v);
    sp_exp = sp_exp - 6'd5;
    chk("vector", {3'h0, v}, {3'h0, cpu_o.vector});
    chk("mask", 1, cpu_o.mask);
    chk("sp_addr", {3'h0, STACK_PAGE, sp_exp}, {3'h0, cpu_o.sp_addr});
  endtask

  // hang guard, far beyond the roughly 120 cycles needed
  initial
  begin
    repeat (5000) @(posedge clock);
    mismatches++;
    results();
  end

  // main sequence
  initial
  begin
    clock = 1'b0;
    rst = 1'b1;
    reset_pin_n = 1'b0;
    bus = '0;
    evt = '0;
    sp_exp = 6'h3f;
    repeat (5) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    #1;
    chk("sp_addr", 16'h00ff, {3'h0, cpu_o.sp_addr});
    chk("vector", 16'h1ffe, {3'h0, cpu_o.vector});
    chk("timer_init", 1, periph_o.timer_init);
    chk("ddr", 0, periph_o.ddr[1:0]);
    chk("serial", 0, {periph_o.serial_enable, periph_o.ext_osc_en});
    repeat (10) @(posedge clock);
    #1;
    chk("run", 0, cpu_o.run);
    @(posedge clock);
    reset_pin_n <= 1'b1;
    wait_vec(5);
    chk("vector", 16'h1ffe, {3'h0, cpu_o.vector});
    rd(TIMER_CONTROL_ADDR, 8'h00);
    rd(SERIAL_CTRL_ADDR, 8'h00);
    rd(8'h30, 8'h00);
    for (k = 0; k < 13; k++)
    begin
      core_m.step(Q_TRAP);
      #1;
      ent(VEC_SWI);
    end
    core_m.step(Q_RETM);
    sp_exp += 6'd5;
    #1;
    chk("mask", 1, cpu_o.mask);
    core_m.step(Q_MCLR);
    pulse(7'h04);
    core_m.step(Q_NOP);
    #1;
    chk("vec_stb", 0, cpu_o.vec_stb);
    rd(TIMER_STATUS_ADDR, 8'h20);
    wr(TIMER_CONTROL_ADDR, 8'h20);
    core_m.step(Q_NOP);
    #1;
    ent(VEC_TIMER);
    wr(COMPARE_LO_ADDR, 8'h00);
    rd(TIMER_STATUS_ADDR, 8'h20);
    wr(COUNT_LO_ADDR, 8'h00);
    rd(TIMER_STATUS_ADDR, 8'h00);
    core_m.step(Q_RET);
    sp_exp += 6'd5;
    #1;
    chk("mask", 0, cpu_o.mask);
    core_m.step(Q_MSET);
    wr(TIMER_CONTROL_ADDR, 8'h61);
    pulse(7'h02);
    core_m.irq(1'b0);
    core_m.step(Q_NOP);
    #1;
    chk("vec_stb", 0, cpu_o.vec_stb);
    chk("cmp_out", 1, periph_o.cmp_out);
    core_m.step(Q_MCLR);
    #1;
    ent(VEC_EXT);
    core_m.step(Q_RET);
    sp_exp += 6'd5;
    #1;
    ent(VEC_EXT);
    core_m.irq(1'b1);
    core_m.step(Q_RET);
    sp_exp += 6'd5;
    #1;
    ent(VEC_TIMER);
    rd(TIMER_STATUS_ADDR, 8'h40);
    wr(COMPARE_LO_ADDR, 8'h00);
    core_m.step(Q_RET);
    sp_exp += 6'd5;
    #1;
    chk("mask_vec", 0, {cpu_o.mask, cpu_o.vec_stb});
    core_m.step(Q_STOP);
    #1;
    chk("osc_run", 0, {cpu_o.osc_on, cpu_o.run});
    core_m.irq(1'b0);
    core_m.irq(1'b1);
    wait_vec(20);
    ent(VEC_EXT);
    core_m.step(Q_RET);
    sp_exp += 6'd5;
    core_m.step(Q_WAIT);
    #1;
    chk("run", 0, cpu_o.run);
    pulse(7'h04);
    wait_vec(10);
    ent(VEC_TIMER);
    wr(DDR_BASE_ADDR, 8'hff);
    wr(SERIAL_CTRL_ADDR, 8'h50);
    @(posedge clock);
    reset_pin_n <= 1'b0;
    repeat (3) @(posedge clock);
    #1;
    chk("ddr", 0, periph_o.ddr[1:0]);
    chk("sp_addr", 16'h00ff, {3'h0, cpu_o.sp_addr});
    chk("mask", 1, cpu_o.mask);
    chk("ser_cmp", 0, {periph_o.serial_enable, periph_o.serial_master,
                       periph_o.cmp_out});
    rd(TIMER_CONTROL_ADDR, 8'h00);
    @(posedge clock);
    reset_pin_n <= 1'b1;
    wait_vec(5);
    chk("vector", 16'h1ffe, {3'h0, cpu_o.vector});
    results();
  end
endmodule

bind irq_reset_ctl irq_reset_ctl_asserts u_chk (
  .clock(clock), .rst(rst), .reset_pin_n(reset_pin_n),
  .irq_pin_n(irq_pin_n), .bus(bus), .evt(evt), .cpu(cpu),
  .rdata(rdata), .cpu_o(cpu_o), .periph_o(periph_o));
